// [rtl/frc_regs.sv]
// flash rewrite control and status registers with suspend handling
`timescale 1ns/100ps
`default_nettype none
module frc_regs (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [frc_pkg::FRC_AW-1:0] addr_i,
    input wire logic [frc_pkg::FRC_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire frc_pkg::frc_seq_s seq_i,
    input wire logic irq_i,
    output logic [frc_pkg::FRC_DW-1:0] rdata_o,
    output frc_pkg::frc_ctl_s ctl_o
);
    import frc_pkg::*;

    // next value of a block disable bit and its arm flag
    function automatic logic [1:0] dis_next(input logic cur, input logic arm,
                                            input logic wr, input logic val);
        logic [1:0] res;
        res = {cur, arm};
        if (wr) begin
            if (val) begin
                res = 2'h3;
            end else begin
                res = {cur & ~arm, 1'h0};
            end
        end
        return res;
    endfunction

    logic rewrite_en;
    logic blk01_en;
    logic stop_bit;
    logic perr;
    logic eerr;
    logic ew1;
    logic b0_dis;
    logic b1_dis;
    logic b0_arm;
    logic b1_arm;
    logic susp_en;
    logic lpr;
    frc_state_e state;
    frc_state_e next_state;
    logic erq;
    logic prq;
    logic next_erq;
    logic next_prq;

    // address decode of the three registers
    wire logic hit_main = addr_i == FRC_MAIN_ADDR;
    wire logic hit_mode = addr_i == FRC_MODE_ADDR;
    wire logic hit_susp = addr_i == FRC_SUSP_ADDR;
    wire logic wr_main = ce_i & wr_i & hit_main;
    wire logic wr_mode = ce_i & wr_i & hit_mode;
    wire logic wr_susp = ce_i & wr_i & hit_susp;
    // mode register writes need rewrite mode
    wire logic wr_mode_ok = wr_mode & rewrite_en;

    // rewrite mode and the bits it forces clear
    wire logic next_rewrite_en = wr_main ? wdata_i[FRC_MAIN_CPU] : rewrite_en;
    wire logic next_blk01 = ~next_rewrite_en ? 1'h0 :
        (wr_main & rewrite_en) ? wdata_i[FRC_MAIN_BLK01] : blk01_en;
    wire logic next_ew1 = ~next_rewrite_en ? 1'h0 :
        wr_mode_ok ? wdata_i[FRC_MODE_EW1] : ew1;
    wire logic [1:0] b0_pair = dis_next(b0_dis, b0_arm, wr_mode_ok,
                                         wdata_i[FRC_MODE_B0]);
    wire logic [1:0] b1_pair = dis_next(b1_dis, b1_arm, wr_mode_ok,
                                         wdata_i[FRC_MODE_B1]);
    wire logic next_b0 = next_rewrite_en & b0_pair[1];
    wire logic next_b1 = next_rewrite_en & b1_pair[1];
    wire logic next_b0_arm = next_rewrite_en & b0_pair[0];
    wire logic next_b1_arm = next_rewrite_en & b1_pair[0];

    // stop bit stores always but acts only in rewrite mode
    wire logic next_stop = wr_main ? wdata_i[FRC_MAIN_STOP] : stop_bit;
    wire logic flash_reset = stop_bit & rewrite_en;

    // error flags: a failing completion wins over a clear
    wire logic perr_set = seq_i.program_done & seq_i.op_error;
    wire logic eerr_set = seq_i.erase_done & seq_i.op_error;
    wire logic next_perr = perr_set | (perr & ~seq_i.clear_status);
    wire logic next_eerr = eerr_set | (eerr & ~seq_i.clear_status);

    // suspend control fields
    wire logic next_susp_en = wr_susp ? wdata_i[FRC_SUSP_EN] : susp_en;
    wire logic next_lpr = wr_susp ? wdata_i[FRC_SUSP_LPR] : lpr;

    // operation status derived from the state
    wire logic erase_act = state == FRC_ERASE || state == FRC_ERASE_SUSP;
    wire logic prog_act = state == FRC_PROG || state == FRC_PROG_SUSP;
    wire logic ready = state == FRC_IDLE;
    wire logic rd_perm = state != FRC_ERASE && state != FRC_PROG;
    wire logic win_e = susp_en & erase_act & ~seq_i.erase_done;
    wire logic win_p = susp_en & prog_act & ~seq_i.program_done;

    // operation tracking with suspend
    always_comb begin
        next_state = state;
        if (flash_reset) begin
            next_state = FRC_IDLE;
        end else begin
            unique case (state)
                FRC_IDLE: begin
                    if (seq_i.erase_start) begin
                        next_state = FRC_ERASE;
                    end else if (seq_i.program_start) begin
                        next_state = FRC_PROG;
                    end
                end
                FRC_ERASE: begin
                    if (seq_i.erase_done) begin
                        next_state = FRC_IDLE;
                    end else if (erq & seq_i.suspend_ack) begin
                        next_state = FRC_ERASE_SUSP;
                    end
                end
                FRC_ERASE_SUSP: begin
                    if (seq_i.erase_done) begin
                        next_state = FRC_IDLE;
                    end else if (~erq) begin
                        next_state = FRC_ERASE;
                    end
                end
                FRC_PROG: begin
                    if (seq_i.program_done) begin
                        next_state = FRC_IDLE;
                    end else if (prq & seq_i.suspend_ack) begin
                        next_state = FRC_PROG_SUSP;
                    end
                end
                FRC_PROG_SUSP: begin
                    if (seq_i.program_done) begin
                        next_state = FRC_IDLE;
                    end else if (~prq) begin
                        next_state = FRC_PROG;
                    end
                end
                default: begin
                    next_state = FRC_IDLE;
                end
            endcase
        end
    end

    // erase suspend request bit
    frc_susp_req u_erq (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .window_i(win_e),
        .wr_i(wr_susp),
        .wval_i(wdata_i[FRC_SUSP_ERQ]),
        .ew1_i(ew1),
        .irq_i(irq_i),
        .req_o(erq),
        .next_req_o(next_erq)
    );

    // program suspend request bit
    frc_susp_req u_prq (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .window_i(win_p),
        .wr_i(wr_susp),
        .wval_i(wdata_i[FRC_SUSP_PRQ]),
        .ew1_i(ew1),
        .irq_i(irq_i),
        .req_o(prq),
        .next_req_o(next_prq)
    );

    // read-back images; ready/busy has no write path
    wire logic [7:0] img_main = {eerr, perr, 2'h0, stop_bit, blk01_en,
                                 rewrite_en, ready};
    wire logic [7:0] img_mode = {1'h1, b1_dis, b0_dis, 3'h0, ew1,
                                 1'h0};
    wire logic [7:0] img_susp = {lpr, rd_perm, 1'h0, prog_act, erase_act,
                                 prq, erq, susp_en};
    wire logic [7:0] rd_mux = hit_main ? img_main :
                              hit_mode ? img_mode :
                              hit_susp ? img_susp : 8'h00;

    // register state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rewrite_en <= 1'h0;
            blk01_en <= 1'h0;
            stop_bit <= 1'h0;
            perr <= 1'h0;
            eerr <= 1'h0;
            ew1 <= 1'h0;
            b0_dis <= 1'h0;
            b1_dis <= 1'h0;
            b0_arm <= 1'h0;
            b1_arm <= 1'h0;
            susp_en <= 1'h0;
            lpr <= 1'h0;
            state <= FRC_IDLE;
        end else if (ce_i) begin
            rewrite_en <= next_rewrite_en;
            blk01_en <= next_blk01;
            stop_bit <= next_stop;
            perr <= next_perr;
            eerr <= next_eerr;
            ew1 <= next_ew1;
            b0_dis <= next_b0;
            b1_dis <= next_b1;
            b0_arm <= next_b0_arm;
            b1_arm <= next_b1_arm;
            susp_en <= next_susp_en;
            lpr <= next_lpr;
            state <= next_state;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // registered controls toward the flash
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctl_o <= '0;
        end else if (ce_i) begin
            ctl_o.cpu_rewrite_enable <= next_rewrite_en;
            ctl_o.interrupt_capable_rewrite_mode <= next_ew1;
            ctl_o.block0_write_ok <= next_blk01 & ~next_b0;
            ctl_o.block1_write_ok <= next_blk01 & ~next_b1;
            ctl_o.erase_suspend_request <= next_erq;
            ctl_o.program_suspend_request <= next_prq;
            ctl_o.flash_stop <= next_stop & next_rewrite_en;
            ctl_o.low_power_read_enable <= next_lpr;
        end
    end

    // sequences used by the checks below
    sequence s_rd_main;
        ce_i && rd_i && hit_main;
    endsequence

    sequence s_rw_off;
        wr_main && !wdata_i[FRC_MAIN_CPU];
    endsequence

    sequence s_erase_go;
        ce_i && state == FRC_IDLE && seq_i.erase_start && !flash_reset;
    endsequence

    sequence s_erase_end;
        ce_i && erase_act && seq_i.erase_done && !flash_reset;
    endsequence

    AST_READY_BUSY: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_rd_main |=> rdata_o[FRC_MAIN_RDY] == $past(ready))
        else $error("ready flag disagrees with operation state");
    AST_BLK01_FORCE: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_rw_off |=> !blk01_en && !ctl_o.block0_write_ok)
        else $error("block enable survived leaving rewrite mode");
    AST_MODE_FORCE: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_rw_off |=> !ew1 && !b0_dis && !b1_dis)
        else $error("mode bits survived leaving rewrite mode");
    AST_STOP_GATED: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && wr_main && wdata_i[FRC_MAIN_STOP] |=>
            ctl_o.flash_stop == rewrite_en && stop_bit)
        else $error("flash stop output wrong for rewrite mode");
    AST_ERR_CLEAR: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && seq_i.clear_status && !seq_i.erase_done |=> !eerr)
        else $error("erase error not cleared");
    AST_ERR_SET: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && perr_set |=> perr)
        else $error("program error not raised");
    AST_DIS_NEEDS_ARM: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_mode_ok && wdata_i[FRC_MODE_B0] |=> b0_dis && b0_arm)
        else $error("block 0 disable not set and armed by one write");
    AST_MODE_RD: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && rd_i && hit_mode |=> rdata_o[FRC_MODE_ONE] &&
            rdata_o[4:2] == 3'h0)
        else $error("fixed mode register bits read wrong");
    AST_SUSP_OFF: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !susp_en && ce_i |=> !erq && !prq)
        else $error("suspend request without suspend enable");
    AST_ERQ_WINDOW: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && !win_e |=> !erq)
        else $error("erase suspend request outside erase");
    AST_PRQ_WINDOW: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && !win_p |=> !prq)
        else $error("program suspend request outside program");
    AST_EW1_AUTO: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && ew1 && win_e && irq_i |=> erq)
        else $error("interrupt did not request erase suspend");
    AST_EW1_NO_SW_SET: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && ew1 && !prq && !irq_i |=> !prq)
        else $error("software set program suspend in interrupt mode");
    AST_ERASE_FLAG: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_erase_go |=> erase_act ##0 rd_perm == 1'h0)
        else $error("erase flag or read lock missing at erase start");
    AST_ERASE_END: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_erase_end |=> !erase_act && ready)
        else $error("erase flag not cleared at erase end");
    AST_RDP_SUSP: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        state == FRC_ERASE_SUSP && ce_i && rd_i && hit_susp |=>
            rdata_o[FRC_SUSP_RDP] && rdata_o[FRC_SUSP_EIP])
        else $error("erase suspend must allow reads and keep erase flag");
    AST_RDP_FLAG: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && rd_i && hit_susp |=> rdata_o[FRC_SUSP_RDP] == $past(rd_perm))
        else $error("read permission flag read wrong");
    AST_LPR: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_susp |=> ctl_o.low_power_read_enable == $past(wdata_i[7]))
        else $error("low-power read output did not follow write");

endmodule
`default_nettype wire

// [pkg/frc_pkg.sv]
// shared constants and types for the flash rewrite control registers
package frc_pkg;

    // register bus widths
    localparam int FRC_AW = 16;
    localparam int FRC_DW = 8;

    // register byte addresses
    localparam logic [15:0] FRC_SUSP_ADDR = 16'h01B3;
    localparam logic [15:0] FRC_MODE_ADDR = 16'h01B5;
    localparam logic [15:0] FRC_MAIN_ADDR = 16'h01B7;

    // flash_main_control_status field positions
    localparam int FRC_MAIN_RDY = 0;
    localparam int FRC_MAIN_CPU = 1;
    localparam int FRC_MAIN_BLK01 = 2;
    localparam int FRC_MAIN_STOP = 3;
    localparam int FRC_MAIN_PERR = 6;
    localparam int FRC_MAIN_EERR = 7;

    // flash_mode_protect_control field positions
    localparam int FRC_MODE_EW1 = 1;
    localparam int FRC_MODE_B0 = 5;
    localparam int FRC_MODE_B1 = 6;
    localparam int FRC_MODE_ONE = 7;

    // flash_suspend_control field positions
    localparam int FRC_SUSP_EN = 0;
    localparam int FRC_SUSP_ERQ = 1;
    localparam int FRC_SUSP_PRQ = 2;
    localparam int FRC_SUSP_EIP = 3;
    localparam int FRC_SUSP_PIP = 4;
    localparam int FRC_SUSP_RDP = 6;
    localparam int FRC_SUSP_LPR = 7;

    // values after reset as read back
    localparam logic [7:0] FRC_MAIN_RST = 8'h01;
    localparam logic [7:0] FRC_MODE_RST = 8'h80;
    localparam logic [7:0] FRC_SUSP_RST = 8'h40;

    // sequencer operation state
    typedef enum logic [2:0] {
        FRC_IDLE = 3'b000,
        FRC_ERASE = 3'b001,
        FRC_ERASE_SUSP = 3'b010,
        FRC_PROG = 3'b011,
        FRC_PROG_SUSP = 3'b100
    } frc_state_e;

    // events from the command sequencer, one-cycle pulses except ack
    typedef struct packed {
        logic erase_start;
        logic program_start;
        logic erase_done;
        logic program_done;
        logic op_error;
        logic suspend_ack;
        logic clear_status;
    } frc_seq_s;

    // controls toward the flash array and sequencer
    typedef struct packed {
        logic cpu_rewrite_enable;
        logic interrupt_capable_rewrite_mode;
        logic block0_write_ok;
        logic block1_write_ok;
        logic erase_suspend_request;
        logic program_suspend_request;
        logic flash_stop;
        logic low_power_read_enable;
    } frc_ctl_s;

endpackage

// [rtl/frc_susp_req.sv]
// one suspend request bit with its write window and interrupt auto-set
`timescale 1ns/100ps
`default_nettype none
module frc_susp_req (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic window_i,
    input wire logic wr_i,
    input wire logic wval_i,
    input wire logic ew1_i,
    input wire logic irq_i,
    output logic req_o,
    output logic next_req_o
);

    // interrupt set wins over a software write of 0
    wire logic auto_set = ew1_i & irq_i;
    // interrupt-capable mode accepts only 0 from software
    wire logic sw_take = wr_i & (~ew1_i | ~wval_i);

    // outside the window the bit clears at the next enabled clock
    assign next_req_o = ~window_i ? 1'h0 :
                        auto_set ? 1'h1 :
                        sw_take ? wval_i : req_o;

    // request flop
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            req_o <= 1'h0;
        end else if (ce_i) begin
            req_o <= next_req_o;
        end
    end

endmodule
`default_nettype wire

// [tb/frc_seq_model.sv]
// sequencer stand-in that starts, suspends and ends flash operations
`timescale 1ns/100ps
`default_nettype none
module frc_seq_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic erase_go_i,
    input wire logic prog_go_i,
    input wire logic fail_i,
    input wire logic slow_i,
    input wire logic clr_i,
    input wire frc_pkg::frc_ctl_s ctl_i,
    output logic busy_o,
    output frc_pkg::frc_seq_s seq_o
);
    import frc_pkg::*;
    logic kind;
    logic [3:0] run_cnt;
    logic [3:0] wait_cnt;
    wire req;

    // request that matters for the running operation
    assign req = kind ? ctl_i.erase_suspend_request
                      : ctl_i.program_suspend_request;

    // pulses last one cycle; a stopped flash drops the operation
    always_ff @(posedge mclk_i) begin
        seq_o.erase_start <= 1'b0;
        seq_o.program_start <= 1'b0;
        seq_o.erase_done <= 1'b0;
        seq_o.program_done <= 1'b0;
        seq_o.op_error <= 1'b0;
        seq_o.clear_status <= clr_i;
        if (rst_i || ctl_i.flash_stop) begin
            busy_o <= 1'b0;
            seq_o <= '0;
        end else if (!busy_o) begin
            busy_o <= erase_go_i | prog_go_i;
            kind <= erase_go_i;
            run_cnt <= 4'h0;
            wait_cnt <= 4'h0;
            seq_o.erase_start <= erase_go_i;
            seq_o.program_start <= prog_go_i;
        end else if (req) begin
            // acknowledge after one cycle, or four when slow
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == (slow_i ? 4'h3 : 4'h0)) begin
                seq_o.suspend_ack <= 1'b1;
            end
        end else begin
            wait_cnt <= 4'h0;
            seq_o.suspend_ack <= 1'b0;
            run_cnt <= run_cnt + 4'h1;
            if (run_cnt == 4'hF) begin
                busy_o <= 1'b0;
                seq_o.erase_done <= kind;
                seq_o.program_done <= !kind;
                seq_o.op_error <= fail_i;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the flash rewrite control registers
`timescale 1ns/100ps
`default_nettype none
module tb;
    import frc_pkg::*;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } frc_row_s;
    localparam logic [15:0] RM = FRC_MAIN_ADDR;
    localparam logic [15:0] RD = FRC_MODE_ADDR;
    localparam logic [15:0] RS = FRC_SUSP_ADDR;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] ev = 4'h0;
    logic slow = 1'b1;
    logic ce = 1'b1;
    logic busy;
    logic [7:0] rdata_o;
    frc_seq_s seq;
    frc_ctl_s ctl_o;
    int mismatches = 0;
    int num_checks = 0;
    // ordinary accesses: write rows give data, read rows the expected byte
    frc_row_s rows [0:27] = '{
        '{1'b1, RM, 8'h00}, '{1'b1, RM, 8'h02},
        '{1'b0, RM, 8'h03},
        '{1'b0, RD, 8'h80},
        '{1'b0, RS, 8'h40},
        '{1'b1, RD, 8'h80}, '{1'b1, RD, 8'h82},
        '{1'b0, RD, 8'h82},
        '{1'b1, RM, 8'h02}, '{1'b1, RM, 8'h06},
        '{1'b0, RM, 8'h07},
        '{1'b1, RD, 8'hE2}, '{1'b0, RD, 8'hE2},
        '{1'b1, RD, 8'h82}, '{1'b0, RD, 8'h82},
        '{1'b1, RM, 8'hC7}, '{1'b0, RM, 8'h07},
        '{1'b1, 16'h01B4, 8'hFF}, '{1'b0, 16'h01B4, 8'h00},
        '{1'b1, RS, 8'h81}, '{1'b0, RS, 8'hC1},
        '{1'b1, RS, 8'h87}, '{1'b0, RS, 8'hC1},
        '{1'b1, RM, 8'h00}, '{1'b0, RM, 8'h01},
        '{1'b0, RD, 8'h80},
        '{1'b1, RD, 8'h82}, '{1'b0, RD, 8'h80}
    };

    always #50 mclk_i = ~mclk_i;

    // device under test beside the sequencer stand-in
    frc_regs i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .seq_i(seq),
        .irq_i(ev[2]), .rdata_o(rdata_o), .ctl_o(ctl_o)
    );
    frc_seq_model i_seq (
        .mclk_i(mclk_i), .rst_i(rst_i), .erase_go_i(ev[0]),
        .prog_go_i(ev[1]), .fail_i(1'b1), .slow_i(slow), .clr_i(ev[3]),
        .ctl_i(ctl_o), .busy_o(busy), .seq_o(seq)
    );

    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe; settle before returning
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask

    // one-cycle pulse on start, interrupt or clear lines
    task automatic pulse(input logic [3:0] m);
        @(posedge mclk_i);
        ev <= m;
        @(posedge mclk_i);
        ev <= 4'h0;
    endtask

    // bounded wait for suspend reached or operation ended
    task automatic wait_for(input logic ack);
        int n;
        n = 0;
        while ((ack ? seq.suspend_ack !== 1'b1 : busy !== 1'b0) && n < 60) begin
            @(posedge mclk_i);
            n++;
        end
        if (n == 60) begin
            mismatches++;
            $display("[ERR] %0t wait ran out", $time);
            test_done();
        end
        @(posedge mclk_i);
    endtask

    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].data);
            end else begin
                rd(rows[i].addr, rows[i].data);
            end
        end
        chk(ctl_o, 8'h01);
        // block write gates, then stop with rewrite mode on
        wr(RM, 8'h02);
        wr(RM, 8'h06);
        wr(RD, 8'hA0);
        chk(ctl_o, 8'h91);
        wr(RM, 8'h0E);
        chk({7'h00, ctl_o.flash_stop}, 8'h01);
        wr(RM, 8'h00);
        wr(RM, 8'h08);
        chk({7'h00, ctl_o.flash_stop}, 8'h00);
        rd(RM, 8'h09);
        // basic-mode erase, slow suspend, failing end, clear status
        wr(RM, 8'h00);
        wr(RM, 8'h02);
        wr(RS, 8'h01);
        pulse(4'h1);
        repeat (2) @(posedge mclk_i);
        rd(RM, 8'h02);
        rd(RS, 8'h09);
        wr(RS, 8'h03);
        wait_for(1'b1);
        rd(RS, 8'h4B);
        chk(ctl_o, 8'h88);
        wr(RS, 8'h01);
        rd(RS, 8'h09);
        wait_for(1'b0);
        rd(RM, 8'h83);
        rd(RS, 8'h41);
        pulse(4'h8);
        rd(RM, 8'h03);
        // interrupt-capable program, prompt suspend on interrupt
        slow <= 1'b0;
        wr(RD, 8'h80);
        wr(RD, 8'h82);
        chk(ctl_o, 8'hC0);
        pulse(4'h2);
        repeat (2) @(posedge mclk_i);
        wr(RS, 8'h05);
        rd(RS, 8'h11);
        pulse(4'h4);
        wait_for(1'b1);
        rd(RS, 8'h55);
        wr(RS, 8'h01);
        wait_for(1'b0);
        rd(RM, 8'h43);
        rd(RS, 8'h41);
        // second reset in mid-run restores every register
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 chk(ctl_o, 8'h00);
        rd(RM, 8'h01);
        rd(RD, 8'h80);
        rd(RS, 8'h40);
        // clock enable low freezes a write
        @(posedge mclk_i);
        ce <= 1'b0;
        wr(RM, 8'h02);
        @(posedge mclk_i);
        ce <= 1'b1;
        rd(RM, 8'h01);
        test_done();
    end
endmodule
`default_nettype wire
